// ===== rtl/mscr_cnt.sv
// down counter with load, used for watchdog and leak settle
`timescale 1ns/100ps
`default_nettype none
module mscr_cnt
  import mscr_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] loadVal,
  input  wire logic             run,
  output var  logic             expired
);
  logic [CNT_W-1:0] cnt;

  always_ff @(posedge core_clk)
    if (!rst_n)
      cnt <= '0;
    else if (clkEn)
    begin
      if (load)
        cnt <= loadVal;
      else if (run && cnt != '0)
        cnt <= cnt - 1'h1;
    end

  assign expired = (cnt == '0) && !load;
endmodule
`default_nettype wire

// ===== rtl/mscr_pkg.sv
// shared constants and types for the system supervision and remote block
package mscr_pkg;

  localparam int CLK_HZ = 20000000;
  // watchdog period in microseconds and its cycle count
  localparam int WDOG_US = 100000;
  localparam int WDOG_CYC = WDOG_US * (CLK_HZ / 1000000);
  // leak message hold-off after power-on, milliseconds
  localparam int LEAK_SETTLE_MS = 2000;
  localparam int LEAK_SETTLE_CYC = LEAK_SETTLE_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 32;

  localparam int SLOTS = 5;
  localparam int HI_LINES = 6;
  localparam int LO_LINES = 7;

  localparam int RMT_LINES = 7;
  // remote line positions
  localparam int RL_PREPARE = 0;
  localparam int RL_START = 1;
  localparam int RL_SHUTDOWN = 2;
  localparam int RL_POWERON = 3;
  localparam int RL_READY = 4;
  localparam int RL_STOP = 5;
  localparam int RL_STARTREQ = 6;

  typedef enum logic [1:0] {
    MSCR_CHAINED = 2'h0,
    MSCR_GLOBAL  = 2'h1,
    MSCR_LOCAL   = 2'h3
  } mscr_mode_t;

  typedef enum logic [1:0] {
    MSCR_INIT = 2'h0,
    MSCR_RUN  = 2'h1,
    MSCR_HUNG = 2'h3
  } mscr_wd_t;

  // logical remote requests, 1 = asserted
  typedef struct packed {
    logic startReq;
    logic stop;
    logic ready;
    logic powerOn;
    logic shutdown;
    logic start;
    logic prepare;
  } mscr_rmt_t;

endpackage

// ===== rtl/mscr_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module mscr_sync
  import mscr_pkg::*;
#(
  parameter logic INIT = 1'h1
)(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic din,
  output var  logic dout
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge core_clk)
    if (!rst_n)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end
    else if (clkEn)
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end

  // a change counts once stages two and three agree
  always_ff @(posedge core_clk)
    if (!rst_n)
      dout <= INIT;
    else if (clkEn && (s2 == s3))
      dout <= s3;
endmodule
`default_nettype wire

// ===== rtl/mscr_top.sv
// system supervision, watchdog, interrupts, leak gating and remote lines
`timescale 1ns/100ps
`default_nettype none
module mscr_top
  import mscr_pkg::*;
#(
  // watchdog and leak settle spans in clock cycles
  parameter int WD_CYC     = WDOG_CYC,
  parameter int SETTLE_CYC = LEAK_SETTLE_CYC
)(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                clkEn,
  input  wire logic                powerOnRst,
  input  wire logic                switchRst,
  input  wire logic                swBusRst,
  input  wire logic                powerFail,
  input  wire logic [2:0]          timerOut,
  input  wire logic [SLOTS-1:0]    slotHiIrq,
  input  wire logic [SLOTS-1:0]    slotMailIrq,
  input  wire logic [1:0]          swIrq,
  input  wire logic                initDone,
  input  wire logic                wdKick,
  input  wire logic                swSysOk,
  input  wire logic                busReq,
  input  wire logic                leakSensorOk,
  input  wire logic                isInjector,
  input  wire mscr_mode_t          rmtMode,
  input  wire mscr_rmt_t           swRmtReq,
  input  wire logic                dispLatchWr,
  input  wire logic [7:0]          dispLatchIn,
  input  wire logic [RMT_LINES-1:0] rmtIn,
  output logic [RMT_LINES-1:0]     rmtOut,
  output logic [RMT_LINES-1:0]     rmtOe,
  output logic                     nmiReq,
  output logic [HI_LINES-1:0]      hiIrq,
  output logic [LO_LINES-1:0]      loIrq,
  output logic                     system_ok_n,
  output logic                     cpuHalt,
  output logic                     watchdog_indicator,
  output logic                     timerBackplane,
  output logic                     timerSoft,
  output logic                     busError,
  output logic                     busDevRst,
  output logic                     dispReset,
  output logic [7:0]               dispLatch,
  output logic                     busGrant,
  output logic                     leakError,
  output mscr_rmt_t                rmtSeen
);
  mscr_wd_t   wdState;
  mscr_wd_t   next_wdState;
  logic       wdExpired;
  logic       settleDone;
  logic       pfSync;
  logic       leakSync;
  logic       hung;
  logic       sysOk;
  logic [RMT_LINES-1:0] rmtSync;
  mscr_rmt_t  drv;
  mscr_rmt_t  en;

  // ===========================================================
  // input synchronisers
  mscr_sync #(.INIT(1'h0)) uPf
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .din      (powerFail),
    .dout     (pfSync)
  );

  mscr_sync #(.INIT(1'h1)) uLeak
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .din      (leakSensorOk),
    .dout     (leakSync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < RMT_LINES; gi++)
    begin : gRmt
      mscr_sync #(.INIT(1'h1)) uR
      (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .din      (rmtIn[gi]),
        .dout     (rmtSync[gi])
      );
    end
  endgenerate

  // ===========================================================
  // watchdog
  // kick reloads, init holds off
  mscr_cnt uWd
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .load     (wdState != MSCR_RUN || wdKick),
    .loadVal  (CNT_W'(WD_CYC)),
    .run      (wdState == MSCR_RUN),
    .expired  (wdExpired)
  );

  always_comb
  begin
    next_wdState = wdState;
    case (wdState)
      MSCR_INIT: if (initDone) next_wdState = MSCR_RUN;
      MSCR_RUN:  if (wdExpired) next_wdState = MSCR_HUNG;
      MSCR_HUNG: next_wdState = MSCR_HUNG;
      default:   next_wdState = MSCR_INIT;
    endcase
  end

  always_ff @(posedge core_clk)
    if (!rst_n)
      wdState <= MSCR_INIT;
    else if (clkEn)
      wdState <= next_wdState;

  assign hung = (wdState == MSCR_HUNG);
  assign cpuHalt = hung;
  // indicator lit in init and hang
  assign watchdog_indicator = (wdState != MSCR_RUN);

  // ===========================================================
  // system ok
  // enabled after init, software or watchdog can clear
  always_ff @(posedge core_clk)
    if (!rst_n)
      sysOk <= 1'h0;
    else if (clkEn)
      sysOk <= initDone && swSysOk && !hung && next_wdState != MSCR_HUNG;

  assign system_ok_n = !sysOk;

  // ===========================================================
  // interrupts
  // nmi from synced powerfail
  assign nmiReq = pfSync;
  // timer sync plus gated slot lines
  assign hiIrq = {slotHiIrq & {SLOTS{!system_ok_n}}, timerOut[0]};
  assign loIrq = {swIrq, slotMailIrq};

  // ===========================================================
  // timer channels
  // three timer outputs routed
  assign timerBackplane = timerOut[0];
  assign timerSoft = timerOut[1];
  assign busError = timerOut[2];

  // ===========================================================
  // resets, display, bus hand-over
  // hardware or software reset of bus devices
  assign busDevRst = powerOnRst || switchRst || swBusRst;
  assign dispReset = powerOnRst;

  // latch not touched by any reset
  always_ff @(posedge core_clk)
    if (clkEn && dispLatchWr)
      dispLatch <= dispLatchIn;

  always_ff @(posedge core_clk)
    if (!rst_n)
      busGrant <= 1'h0;
    else if (clkEn)
      busGrant <= busReq;

  // ===========================================================
  // leak sensing
  // settle masks leak after power-on
  mscr_cnt uSettle
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .load     (powerOnRst),
    .loadVal  (CNT_W'(SETTLE_CYC)),
    .run      (1'h1),
    .expired  (settleDone)
  );

  always_ff @(posedge core_clk)
    if (!rst_n)
      leakError <= 1'h0;
    else if (clkEn)
      leakError <= settleDone && !leakSync;

  // ===========================================================
  // remote lines
  // low level on a line reads as true
  assign rmtSeen = mscr_rmt_t'(~rmtSync);

  always_comb
  begin
    en = '0;
    en.ready = 1'h1;
    en.shutdown = 1'h1;
    case (rmtMode)
      MSCR_CHAINED:
      begin
        en.prepare = isInjector;
        en.start = isInjector;
        en.stop = 1'h1;
        // pump or detector issues start request
        en.startReq = !isInjector;
      end
      MSCR_GLOBAL:
      begin
        en.prepare = isInjector;
        en.start = 1'h1;
        en.stop = 1'h1;
      end
      MSCR_LOCAL: en.stop = 1'h0;
      default:    en.stop = 1'h0;
    endcase
  end

  always_comb
  begin
    drv = swRmtReq & en;
    // hardware shutdown on leak or hang
    drv.shutdown = swRmtReq.shutdown || leakError || hung;
    drv.powerOn = 1'h0;
    // ready is high-true: pull low when not ready
    drv.ready = !swRmtReq.ready;
  end

  // open collector: only ever drive low
  // release the line when not asserting
  assign rmtOut = '0;
  // an enabled request pulls its line low; ready pulls low when not requested, power-on never
  assign rmtOe = drv;

  // ===========================================================
  // assertions
  default clocking asrtClk @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence wdRunOut;
    clkEn && rst_n && wdState == MSCR_RUN && wdExpired;
  endsequence

  sequence hangShown;
    cpuHalt && system_ok_n && watchdog_indicator;
  endsequence

  wd_expiry_halt_a: assert property (wdRunOut |=> hangShown)
    else $error("watchdog expiry did not halt and disable");
  slot_gate_a: assert property (system_ok_n |-> hiIrq[HI_LINES-1:1] == '0)
    else $error("slot interrupt passed while system not ok");
  sysok_init_a: assert property (clkEn && rst_n && !initDone |=> system_ok_n)
    else $error("system ok asserted before init done");
  hw_shutdown_a: assert property ((hung || leakError) |-> rmtOe[RL_SHUTDOWN])
    else $error("shutdown line not driven on leak or hang");
  open_coll_a: assert property (rmtOut == '0)
    else $error("remote line driven high");
  local_quiet_a: assert property (rmtMode == MSCR_LOCAL |-> !rmtOe[RL_PREPARE] &&
    !rmtOe[RL_START] && !rmtOe[RL_STOP] && !rmtOe[RL_STARTREQ])
    else $error("run line driven in local mode");
  poweron_free_a: assert property (rmtOe[RL_POWERON] == 1'h0)
    else $error("power-on line driven");
  grant_follow_a: assert property (clkEn && rst_n |=> busGrant == $past(busReq))
    else $error("bus grant does not follow request");
  settle_mask_a: assert property (clkEn && rst_n && !settleDone |=> !leakError)
    else $error("leak error raised during settle time");
endmodule
`default_nettype wire

// ===== tb/module_system_control_remote_test.sv
// self-checking bench for the supervision and remote block
`timescale 1ns/100ps
`default_nettype none
module module_system_control_remote_test
  import mscr_pkg::*;
;
  logic       core_clk = 1'h0, rst_n = 1'h0, clkEn = 1'h1;
  logic       powerOnRst = 1'h0, switchRst = 1'h0, swBusRst = 1'h0;
  logic       powerFail = 1'h0, initDone = 1'h0, wdKick = 1'h0;
  logic       swSysOk = 1'h0, busReq = 1'h0, leakSensorOk = 1'h1;
  logic       isInjector = 1'h0, dispLatchWr = 1'h0;
  logic [2:0] timerOut = 3'h0;
  logic [4:0] slotHiIrq = 5'h00, slotMailIrq = 5'h00;
  logic [1:0] swIrq = 2'h0;
  logic [7:0] dispLatchIn = 8'h00, dispLatch;
  logic [6:0] rmtIn, rmtOut, rmtOe, peerOe, loIrq;
  logic [6:0] pullReq = 7'h00;
  logic [5:0] hiIrq;
  logic       nmiReq, system_ok_n, cpuHalt, watchdog_indicator;
  logic       timerBackplane, timerSoft, busError, busDevRst;
  logic       dispReset, busGrant, leakError;
  mscr_mode_t rmtMode = MSCR_LOCAL;
  mscr_rmt_t  swRmtReq = '0;
  mscr_rmt_t  rmtSeen;
  int         failures = 0;
  int         cmpCount = 0;
  // short spans so that expiry and settle fit the run
  localparam int WD_TB = 40;
  localparam int SETTLE_TB = 60;
  mscr_mode_t modeTab [6] = '{MSCR_CHAINED, MSCR_GLOBAL, MSCR_LOCAL,
                              MSCR_CHAINED, MSCR_GLOBAL, MSCR_LOCAL};
  logic [6:0] oeTab [6] = '{7'h64, 7'h26, 7'h04, 7'h27, 7'h27, 7'h04};

  // ==========================================
  // clock, wired-or lines with pull-up
  always #25 core_clk = ~core_clk;
  assign rmtIn = ~(rmtOe | peerOe);

  mscr_top #(.WD_CYC(WD_TB), .SETTLE_CYC(SETTLE_TB)) u_dut (
    .core_clk, .rst_n, .clkEn, .powerOnRst, .switchRst, .swBusRst,
    .powerFail, .timerOut, .slotHiIrq, .slotMailIrq, .swIrq, .initDone,
    .wdKick, .swSysOk, .busReq, .leakSensorOk, .isInjector, .rmtMode,
    .swRmtReq, .dispLatchWr, .dispLatchIn, .rmtIn, .rmtOut, .rmtOe,
    .nmiReq, .hiIrq, .loIrq, .system_ok_n, .cpuHalt, .watchdog_indicator,
    .timerBackplane, .timerSoft, .busError, .busDevRst, .dispReset,
    .dispLatch, .busGrant, .leakError, .rmtSeen
  );

  mscr_remote_peer u_peer (
    .core_clk, .pullReq, .peerOe
  );

  // ==========================================
  // helpers
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic kick;
    @(posedge core_clk);
    wdKick <= 1'h1;
    @(posedge core_clk);
    wdKick <= 1'h0;
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================
  // watchdog against a hang
  initial
  begin
    #(3000 * 50);
    failures++;
    summarize();
  end

  // ==========================================
  // tests
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    cyc(0);
    check("sysOkN", system_ok_n, 8'h01);
    check("led", watchdog_indicator, 8'h01);
    check("halt", cpuHalt, 8'h00);
    check("oe", rmtOe, 8'h10);
    @(posedge core_clk);
    initDone <= 1'h1;
    swSysOk <= 1'h1;
    wdKick <= 1'h1;
    cyc(2);
    check("sysOkN", system_ok_n, 8'h00);
    check("led", watchdog_indicator, 8'h00);
    check("halt", cpuHalt, 8'h00);
    $display("test init done");
    @(posedge core_clk);
    timerOut <= 3'h5;
    slotHiIrq <= 5'h15;
    slotMailIrq <= 5'h0A;
    swIrq <= 2'h2;
    powerFail <= 1'h1;
    cyc(8);
    check("hiIrq", hiIrq, 8'h2B);
    check("loIrq", loIrq, 8'h4A);
    check("nmi", nmiReq, 8'h01);
    check("timers", {timerBackplane, timerSoft, busError}, 8'h05);
    @(posedge core_clk);
    swSysOk <= 1'h0;
    cyc(2);
    check("sysOkN", system_ok_n, 8'h01);
    check("hiIrq", hiIrq, 8'h01);
    @(posedge core_clk);
    swSysOk <= 1'h1;
    busReq <= 1'h1;
    cyc(2);
    check("grant", busGrant, 8'h01);
    $display("test interrupts done");
    @(posedge core_clk);
    busReq <= 1'h0;
    leakSensorOk <= 1'h0;
    cyc(8);
    check("grant", busGrant, 8'h00);
    check("leak", leakError, 8'h01);
    check("oe", rmtOe, 8'h14);
    @(posedge core_clk);
    leakSensorOk <= 1'h1;
    cyc(8);
    check("oe", rmtOe, 8'h10);
    $display("test leak done");
    for (int i = 0; i < 6; i++)
    begin
      @(posedge core_clk);
      swRmtReq <= mscr_rmt_t'(7'h77);
      rmtMode <= modeTab[i];
      isInjector <= (i > 2);
      cyc(3);
      check("oe", rmtOe, oeTab[i]);
      check("out", rmtOut, 8'h00);
    end
    @(posedge core_clk);
    swRmtReq <= '0;
    pullReq <= 7'h22;
    cyc(6);
    check("seen", rmtSeen, 8'h32);
    $display("test remote done");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      dispLatchWr <= (i == 0);
      dispLatchIn <= 8'hA5;
      {powerOnRst, switchRst, swBusRst} <= 3'h4 >> i;
      cyc(1);
      check("devRst", busDevRst, 8'h01);
      check("dispRst", dispReset, {7'h00, i == 0});
    end
    check("latch", dispLatch, 8'hA5);
    $display("test resets done");
    // power-on pulse above restarted the settle span
    @(posedge core_clk);
    leakSensorOk <= 1'h0;
    cyc(8);
    check("leak", leakError, 8'h00);
    cyc(SETTLE_TB);
    check("leak", leakError, 8'h01);
    $display("test settle done");
    @(posedge core_clk);
    leakSensorOk <= 1'h1;
    wdKick <= 1'h0;
    cyc(WD_TB - 10);
    check("halt", cpuHalt, 8'h00);
    kick();
    cyc(WD_TB - 10);
    check("halt", cpuHalt, 8'h00);
    cyc(12);
    check("halt", cpuHalt, 8'h01);
    check("sysOkN", system_ok_n, 8'h01);
    check("led", watchdog_indicator, 8'h01);
    check("oe", rmtOe, 8'h14);
    $display("test watchdog done");
    @(posedge core_clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    cyc(0);
    check("halt", cpuHalt, 8'h00);
    check("sysOkN", system_ok_n, 8'h01);
    check("led", watchdog_indicator, 8'h01);
    cyc(2);
    check("sysOkN", system_ok_n, 8'h00);
    check("led", watchdog_indicator, 8'h00);
    check("latch", dispLatch, 8'hA5);
    $display("test restart done");
    summarize();
  end
endmodule
`default_nettype wire

// ===== tb/mscr_remote_peer.sv
// model of the other modules sharing the wired-or remote lines
`timescale 1ns/100ps
`default_nettype none
module mscr_remote_peer
  import mscr_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic [RMT_LINES-1:0] pullReq,
  output var  logic [RMT_LINES-1:0] peerOe
);
  // ==========================================
  // open collector drive
  // pull low only, else release
  // ready and power-on follow pullReq like every other line
  always_ff @(posedge core_clk)
    peerOe <= pullReq;
endmodule
`default_nettype wire
